// file: rtl/lam_pkg.sv
/*
 * Shared constants for the line alarm monitor: detection criteria,
 * status and flag bit positions, configuration bit positions and the
 * reference clock synthesis figures.
 * Assumes a 125 MHz system clock and bit-rate strobes from the line path.
 */
package lam_pkg;

    // ==========================================================
    // Clocking
    localparam longint unsigned CLK_HZ      = 125_000_000;
    localparam longint unsigned REF_T1_HZ   = 1_544_000;
    localparam longint unsigned REF_E1_HZ   = 2_048_000;
    localparam int              REF_ACC_W   = 24;
    localparam logic [23:0]     REF_INC_T1  = 24'((REF_T1_HZ * (64'd1 << REF_ACC_W)) / CLK_HZ);
    localparam logic [23:0]     REF_INC_E1  = 24'((REF_E1_HZ * (64'd1 << REF_ACC_W)) / CLK_HZ);

    // ==========================================================
    // System-side absence criteria, in bit intervals
    localparam logic [11:0] SYS_N_T1_0  = 12'h0AF;
    localparam logic [11:0] SYS_N_T1_1  = 12'h608;
    localparam logic [11:0] SYS_N_E1_0  = 12'h020;
    localparam logic [11:0] SYS_N_E1_1  = 12'h800;
    localparam logic [7:0]  SYS_M_T1    = 8'hAF;
    localparam logic [7:0]  SYS_M_E1    = 8'h20;
    localparam logic [6:0]  SYS_ZLIM_T1 = 7'h64;
    localparam logic [6:0]  SYS_ZLIM_E1 = 7'h10;

    // Transmit-line absence periods, in pulse intervals, per duration code.
    localparam logic [7:0] TX_DUR_0 = 8'h10;
    localparam logic [7:0] TX_DUR_1 = 8'h20;
    localparam logic [7:0] TX_DUR_2 = 8'h40;
    localparam logic [7:0] TX_DUR_3 = 8'h80;

    // ==========================================================
    // All-ones alarm criteria
    localparam logic [12:0] AIS_LEN_E1  = 13'h01FF;
    localparam logic [12:0] AIS_LEN_T1  = 13'h1FFF;
    localparam logic [3:0]  AIS_ZTHR_E1 = 4'h3;
    localparam logic [3:0]  AIS_ZTHR_T1 = 4'h9;

    // ==========================================================
    // Bit positions
    localparam int ST_SYS_ABSENT   = 1;
    localparam int ST_TXLN_ABSENT  = 2;
    localparam int ST_RX_ALARM     = 6;
    localparam int ST_TX_ALARM     = 7;
    localparam int ES_ABSENCE      = 1;
    localparam int ES_TX_LINE      = 2;
    localparam int ES_ALARM        = 6;
    localparam int AO_TX_LINE      = 0;
    localparam int AO_TX_SYS       = 1;
    localparam int AO_RX_LINE      = 2;
    localparam int AO_RX_SYS       = 3;

    // Transmit system interface formats.
    typedef enum logic [1:0] {
        LAM_FMT_SINGLE  = 2'h0,
        LAM_FMT_DUAL_NRZ = 2'h1,
        LAM_FMT_DUAL_RZ = 2'h2
    } lam_format_t;

endpackage

// file: rtl/lam_ones_detect.sv
/*
 * All-ones alarm detector for one bit stream: counts zeros per block and
 * declares or clears the alarm by the block criteria of the line mode.
 * Assumes i_bit_valid marks one bit interval, synchronous to i_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module lam_ones_detect
    import lam_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // Mode
    input  wire logic i_e1_mode,
    input  wire logic i_criteria_select,
    // Bit stream
    input  wire logic i_bit_valid,
    input  wire logic i_bit,
    // Result
    output logic      o_alarm
);
    typedef struct packed {
        logic [12:0] bitcnt;
        logic [3:0]  zeros;
        logic        prev_low;
        logic        alarm;
    } lam_od_state_t;

    lam_od_state_t q, d;

    always_comb begin
        logic [3:0]  zeros_n;
        logic        low;
        logic [12:0] last;
        logic [3:0]  thr;
        zeros_n = q.zeros;
        low     = 1'b0;
        last    = i_e1_mode ? AIS_LEN_E1 : AIS_LEN_T1;
        thr     = i_e1_mode ? AIS_ZTHR_E1 : AIS_ZTHR_T1;
        d       = q;
        if (i_bit_valid) begin
            if (!i_bit && q.zeros != 4'hF) begin
                zeros_n = q.zeros + 4'h1;
            end
            low = zeros_n < thr;
            if (q.bitcnt >= last) begin
                d.bitcnt   = 13'h0000;
                d.zeros    = 4'h0;
                d.prev_low = low;
                if (i_e1_mode && !i_criteria_select) begin
                    // Two blocks in a row must agree before the state moves.
                    if (low && q.prev_low) begin
                        d.alarm = 1'b1;
                    end else if (!low && !q.prev_low) begin
                        d.alarm = 1'b0;
                    end
                end else begin
                    d.alarm = low;
                end
            end else begin
                d.bitcnt = q.bitcnt + 13'h0001;
                d.zeros  = zeros_n;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_alarm = q.alarm;
endmodule
`default_nettype wire

// file: rtl/lam_ref_clock.sv
/*
 * Reference clock synthesis: a phase accumulator on the system clock
 * produces the 1.544 MHz or 2.048 MHz bit-rate clock and a tick per cycle.
 * Assumes the line mode input changes only while the line is idle.
 */
`timescale 1ns/1ps
`default_nettype none
module lam_ref_clock
    import lam_pkg::*;
(
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    // Mode
    input  wire logic i_e1_mode,
    // Reference clock
    output logic      o_ref_clock,
    output logic      o_ref_tick
);
    typedef struct packed {
        logic [23:0] acc;
        logic        tick;
    } lam_rc_state_t;

    lam_rc_state_t q, d;

    // Jitter is one system clock period, which the line side tolerates.
    always_comb begin
        d      = q;
        d.acc  = q.acc + (i_e1_mode ? REF_INC_E1 : REF_INC_T1);
        d.tick = d.acc[23] && !q.acc[23];
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign o_ref_clock = q.acc[23];
    assign o_ref_tick  = q.tick;
endmodule
`default_nettype wire

// file: rtl/lam_alarm_monitor.sv
/*
 * Per-channel alarm monitor: system-side and transmit-line signal
 * absence, receive and transmit all-ones alarms, event flags, the
 * interrupt, indicator pins and automatic all-ones insertion.
 * Assumes bit strobes and data come from the line path in the i_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module lam_alarm_monitor
    import lam_pkg::*;
(
    // Clock and reset
    input  wire logic           i_clk,
    input  wire logic           i_reset_n,
    // Mode and configuration
    input  wire logic           i_e1_mode,
    input  wire logic           i_criteria_select,
    input  wire lam_pkg::lam_format_t i_sys_format,
    input  wire logic [1:0]     i_tx_amplitude_threshold,
    input  wire logic [1:0]     i_tx_absence_duration,
    input  wire logic [7:0]     i_edge_select_reg,
    input  wire logic [3:0]     i_auto_ones_config,
    input  wire logic [1:0]     i_tx_indicator_select,
    // Event masks and clears (a: absence, b: alarms)
    input  wire logic [7:0]     i_event_masks_a,
    input  wire logic [7:0]     i_event_masks_b,
    input  wire logic [7:0]     i_event_clear_a,
    input  wire logic [7:0]     i_event_clear_b,
    // Transmit system data
    input  wire logic           i_tx_sys_bit_valid,
    input  wire logic           i_tx_sys_pos,
    input  wire logic           i_tx_sys_neg,
    // Transmit line amplitude monitor
    input  wire logic           i_tx_interval_valid,
    input  wire logic [1:0]     i_tx_pulse_amplitude,
    // Receive line data and line absence from the receiver
    input  wire logic           i_rx_bit_valid,
    input  wire logic           i_rx_pos,
    input  wire logic           i_rx_neg,
    input  wire logic           i_rx_clock,
    input  wire logic           i_rx_line_signal_absent,
    // Transmit line data from the encoder
    input  wire logic           i_tx_tip_data,
    input  wire logic           i_tx_ring_data,
    // Pattern generator
    input  wire logic           i_pattern_active,
    input  wire logic           i_pattern_in_rx,
    input  wire logic           i_pattern_pos,
    input  wire logic           i_pattern_neg,
    input  wire logic           i_pattern_clock,
    // Status and events
    output logic [7:0]          o_status_reg_a,
    output logic [7:0]          o_status_reg_b,
    output logic [7:0]          o_event_flags_a,
    output logic [7:0]          o_event_flags_b,
    output logic                o_interrupt,
    output logic [3:0]          o_counter_event,
    output logic                o_tx_multiplex_indicator,
    output logic                o_rx_multiplex_indicator,
    // Receive outputs
    output logic                o_rx_single_rail_out,
    output logic                o_rx_positive_rail_out,
    output logic                o_rx_negative_rail_out,
    output logic                o_rx_clock_out,
    // Transmit line outputs
    output logic                o_tx_line_tip,
    output logic                o_tx_line_ring
);
    // ==========================================================
    // State
    typedef struct packed {
        logic        sa;
        logic [11:0] sa_zrun;
        logic        sa_inwin;
        logic [7:0]  sa_win;
        logic [7:0]  sa_marks;
        logic [6:0]  sa_wzrun;
        logic        tl;
        logic [7:0]  tl_cnt;
        logic [3:0]  st_prev;
        logic [3:0]  flags;
        logic        intr;
        logic [3:0]  cnt_ev;
        logic        tx_ind;
        logic        rx_ind;
        logic        pol;
        logic        rx_single;
        logic        rx_p;
        logic        rx_n;
        logic        rx_c;
        logic        tx_t;
        logic        tx_r;
    } lam_state_t;

    lam_state_t q, d;
    logic       rx_alarm;
    logic       tx_alarm;
    logic       ref_clock;
    logic       ref_tick;

    // Each path gets its own detector so neither stalls the other.
    lam_ones_detect u_rx_ones (
        .i_clk             (i_clk),
        .i_reset_n         (i_reset_n),
        .i_e1_mode         (i_e1_mode),
        .i_criteria_select (i_criteria_select),
        .i_bit_valid       (i_rx_bit_valid),
        .i_bit             (i_rx_pos | i_rx_neg),
        .o_alarm           (rx_alarm)
    );

    lam_ones_detect u_tx_ones (
        .i_clk             (i_clk),
        .i_reset_n         (i_reset_n),
        .i_e1_mode         (i_e1_mode),
        .i_criteria_select (i_criteria_select),
        .i_bit_valid       (i_tx_sys_bit_valid),
        .i_bit             (i_tx_sys_pos | i_tx_sys_neg),
        .o_alarm           (tx_alarm)
    );

    lam_ref_clock u_ref (
        .i_clk       (i_clk),
        .i_reset_n   (i_reset_n),
        .i_e1_mode   (i_e1_mode),
        .o_ref_clock (ref_clock),
        .o_ref_tick  (ref_tick)
    );

    // ==========================================================
    // Decoding helpers
    function automatic logic [11:0] sys_declare_count(input logic e1, input logic sel);
        if (e1) begin
            return sel ? SYS_N_E1_1 : SYS_N_E1_0;
        end
        return sel ? SYS_N_T1_1 : SYS_N_T1_0;
    endfunction

    function automatic logic [7:0] tx_duration(input logic [1:0] code);
        case (code)
            2'h0:    return TX_DUR_0;
            2'h1:    return TX_DUR_1;
            2'h2:    return TX_DUR_2;
            default: return TX_DUR_3;
        endcase
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        logic        dual;
        logic        mark;
        logic [7:0]  mlim;
        logic [6:0]  zlim;
        logic [7:0]  win_n;
        logic [7:0]  marks_n;
        logic [6:0]  wz_n;
        logic [3:0]  st;
        logic [3:0]  es;
        logic [3:0]  chg;
        logic [3:0]  clr;
        logic [3:0]  msk;
        logic        rx_ones;
        logic        tx_ones;
        st      = 4'h0;
        es      = 4'h0;
        chg     = 4'h0;
        clr     = 4'h0;
        msk     = 4'h0;
        rx_ones = 1'b0;
        tx_ones = 1'b0;
        dual    = (i_sys_format == LAM_FMT_DUAL_NRZ) || (i_sys_format == LAM_FMT_DUAL_RZ);
        mark    = i_tx_sys_pos | i_tx_sys_neg;
        mlim    = i_e1_mode ? SYS_M_E1 : SYS_M_T1;
        zlim    = i_e1_mode ? SYS_ZLIM_E1 : SYS_ZLIM_T1;
        win_n   = q.sa_win + 8'h01;
        marks_n = q.sa_marks + {7'h00, mark};
        wz_n    = mark ? 7'h00 : q.sa_wzrun + 7'h01;
        d       = q;

        // System-side absence; single-rail data carries no pulse information.
        if (!dual) begin
            d.sa       = 1'b0;
            d.sa_zrun  = 12'h000;
            d.sa_inwin = 1'b0;
        end else if (i_tx_sys_bit_valid) begin
            if (mark) begin
                d.sa_zrun = 12'h000;
            end else if (q.sa_zrun != 12'hFFF) begin
                d.sa_zrun = q.sa_zrun + 12'h001;
            end
            if (!q.sa) begin
                d.sa_inwin = 1'b0;
                if (!mark && (q.sa_zrun + 12'h001) >= sys_declare_count(i_e1_mode,
                                                                       i_criteria_select)) begin
                    d.sa = 1'b1;
                end
            end else if (!q.sa_inwin) begin
                if (mark) begin
                    d.sa_inwin = 1'b1;
                    d.sa_win   = 8'h01;
                    d.sa_marks = 8'h01;
                    d.sa_wzrun = 7'h00;
                end
            end else begin
                d.sa_win   = win_n;
                d.sa_marks = marks_n;
                d.sa_wzrun = wz_n;
                // A long zero run spoils the window; the next mark restarts it.
                if (wz_n >= zlim) begin
                    d.sa_inwin = 1'b0;
                end else if (win_n >= mlim) begin
                    d.sa_inwin = 1'b0;
                    if ({marks_n, 3'h0} >= {3'h0, mlim}) begin
                        d.sa = 1'b0;
                    end
                end
            end
        end

        // Transmit-line absence. The monitor senses the shared line itself, so
        // a channel with its output in high impedance still sees the partner.
        if (i_tx_interval_valid) begin
            if (i_tx_pulse_amplitude > i_tx_amplitude_threshold) begin
                d.tl     = 1'b0;
                d.tl_cnt = 8'h00;
            end else begin
                if (q.tl_cnt != 8'hFF) begin
                    d.tl_cnt = q.tl_cnt + 8'h01;
                end
                if ((q.tl_cnt + 8'h01) >= tx_duration(i_tx_absence_duration)) begin
                    d.tl = 1'b1;
                end
            end
        end

        // Events: bit 0 system, 1 transmit line, 2 receive alarm, 3 transmit alarm.
        st  = {tx_alarm, rx_alarm, q.tl, q.sa};
        es  = {i_edge_select_reg[ES_ALARM], i_edge_select_reg[ES_ALARM],
               i_edge_select_reg[ES_TX_LINE], i_edge_select_reg[ES_ABSENCE]};
        clr = {i_event_clear_b[ST_TX_ALARM], i_event_clear_b[ST_RX_ALARM],
               i_event_clear_a[ST_TXLN_ABSENT], i_event_clear_a[ST_SYS_ABSENT]};
        msk = {i_event_masks_b[ST_TX_ALARM], i_event_masks_b[ST_RX_ALARM],
               i_event_masks_a[ST_TXLN_ABSENT], i_event_masks_a[ST_SYS_ABSENT]};
        for (int i = 0; i < 4; i++) begin
            chg[i] = es[i] ? (st[i] ^ q.st_prev[i]) : (st[i] & ~q.st_prev[i]);
        end
        d.st_prev = st;
        // A new event in the clearing cycle survives the clear.
        d.flags   = (q.flags & ~clr) | chg;
        d.intr    = |(d.flags & ~msk);
        d.cnt_ev  = st & ~q.st_prev;

        case (i_tx_indicator_select)
            2'h0:    d.tx_ind = q.sa;
            2'h1:    d.tx_ind = q.tl;
            2'h2:    d.tx_ind = tx_alarm;
            default: d.tx_ind = 1'b0;
        endcase
        d.rx_ind = rx_alarm;

        // All-ones insertion. Marks alternate polarity on each reference tick so
        // the dual-rail stream stays a legal bipolar signal.
        if (ref_tick) begin
            d.pol = ~q.pol;
        end
        rx_ones = (i_auto_ones_config[AO_RX_LINE] & i_rx_line_signal_absent)
                | (i_auto_ones_config[AO_RX_SYS] & q.sa);
        tx_ones = (i_auto_ones_config[AO_TX_LINE] & i_rx_line_signal_absent)
                | (i_auto_ones_config[AO_TX_SYS] & q.sa);

        if (i_pattern_active && i_pattern_in_rx) begin
            d.rx_single = i_pattern_pos | i_pattern_neg;
            d.rx_p      = i_pattern_pos;
            d.rx_n      = i_pattern_neg;
            d.rx_c      = i_pattern_clock;
        end else if (rx_ones) begin
            d.rx_single = 1'b1;
            d.rx_p      = q.pol;
            d.rx_n      = ~q.pol;
            d.rx_c      = ref_clock;
        end else begin
            d.rx_single = i_rx_pos | i_rx_neg;
            d.rx_p      = i_rx_pos;
            d.rx_n      = i_rx_neg;
            d.rx_c      = i_rx_clock;
        end

        if (i_pattern_active && !i_pattern_in_rx) begin
            d.tx_t = i_pattern_pos;
            d.tx_r = i_pattern_neg;
        end else if (tx_ones) begin
            d.tx_t = q.pol;
            d.tx_r = ~q.pol;
        end else begin
            d.tx_t = i_tx_tip_data;
            d.tx_r = i_tx_ring_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // ==========================================================
    // Outputs, all straight from state flip-flops
    always_comb begin
        o_status_reg_a                 = 8'h00;
        o_status_reg_a[ST_SYS_ABSENT]  = q.sa;
        o_status_reg_a[ST_TXLN_ABSENT] = q.tl;
        o_status_reg_b                 = 8'h00;
        o_status_reg_b[ST_RX_ALARM]    = q.st_prev[2];
        o_status_reg_b[ST_TX_ALARM]    = q.st_prev[3];
        o_event_flags_a                = 8'h00;
        o_event_flags_a[ST_SYS_ABSENT] = q.flags[0];
        o_event_flags_a[ST_TXLN_ABSENT] = q.flags[1];
        o_event_flags_b                = 8'h00;
        o_event_flags_b[ST_RX_ALARM]   = q.flags[2];
        o_event_flags_b[ST_TX_ALARM]   = q.flags[3];
    end

    assign o_interrupt              = q.intr;
    assign o_counter_event          = q.cnt_ev;
    assign o_tx_multiplex_indicator = q.tx_ind;
    assign o_rx_multiplex_indicator = q.rx_ind;
    assign o_rx_single_rail_out     = q.rx_single;
    assign o_rx_positive_rail_out   = q.rx_p;
    assign o_rx_negative_rail_out   = q.rx_n;
    assign o_rx_clock_out           = q.rx_c;
    assign o_tx_line_tip            = q.tx_t;
    assign o_tx_line_ring           = q.tx_r;
endmodule
`default_nettype wire

// file: tb/lam_alarm_monitor_asserts.sv
/* Port checker for the line alarm monitor.
   Assumes it is bound to lam_alarm_monitor and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module lam_alarm_monitor_asserts
    import lam_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_reset_n,
    // Observed inputs
    input  wire lam_pkg::lam_format_t i_sys_format,
    input  wire logic                i_tx_interval_valid,
    input  wire logic [1:0]          i_tx_pulse_amplitude,
    input  wire logic [1:0]          i_tx_amplitude_threshold,
    input  wire logic [7:0]          i_event_masks_a,
    input  wire logic [7:0]          i_event_clear_a,
    // Observed outputs
    input  wire logic [7:0]          o_status_reg_a,
    input  wire logic [7:0]          o_status_reg_b,
    input  wire logic [7:0]          o_event_flags_a,
    input  wire logic [7:0]          o_event_flags_b,
    input  wire logic                o_interrupt,
    input  wire logic [3:0]          o_counter_event
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    chk_single_rail_quiet: assert property (
        (i_sys_format == LAM_FMT_SINGLE) [*2] |=> !o_status_reg_a[1]) else $error("absence in single rail");
    chk_sys_event_out: assert property (
        $rose(o_status_reg_a[1]) |=> o_event_flags_a[1] && o_counter_event[0]) else $error("no sys event");
    chk_irq_unmasked: assert property (
        (o_event_flags_a[1] && !i_event_masks_a[1]) [*2] |-> o_interrupt) else $error("irq missing");
    chk_flag_clear: assert property (
        i_event_clear_a[1] && $stable(o_status_reg_a[1]) |=> !o_event_flags_a[1]) else $error("flag kept");
    chk_valid_pulse_clear: assert property (
        i_tx_interval_valid && (i_tx_pulse_amplitude > i_tx_amplitude_threshold)
        |=> !o_status_reg_a[2]) else $error("line absence kept");
    chk_txline_flag: assert property (
        $rose(o_status_reg_a[2]) |=> o_event_flags_a[2] && o_counter_event[1]) else $error("no tx flag");
    chk_rx_alarm_flag: assert property (
        $rose(o_status_reg_b[6]) |-> o_event_flags_b[6] && o_counter_event[2]) else $error("no rx flag");
    chk_unused_zero: assert property (
        (o_status_reg_a & 8'hF9) == 8'h00 && (o_status_reg_b & 8'h3F) == 8'h00) else $error("stray bit");
endmodule
bind lam_alarm_monitor lam_alarm_monitor_asserts u_chk (.i_clk(i_clk), .i_reset_n(i_reset_n),
    .i_sys_format(i_sys_format), .i_tx_interval_valid(i_tx_interval_valid),
    .i_tx_pulse_amplitude(i_tx_pulse_amplitude), .i_tx_amplitude_threshold(i_tx_amplitude_threshold),
    .i_event_masks_a(i_event_masks_a), .i_event_clear_a(i_event_clear_a),
    .o_status_reg_a(o_status_reg_a), .o_status_reg_b(o_status_reg_b),
    .o_event_flags_a(o_event_flags_a), .o_event_flags_b(o_event_flags_b),
    .o_interrupt(o_interrupt), .o_counter_event(o_counter_event));
`default_nettype wire

// file: tb/lam_far_side.sv
/* Far-side bit source: one interval per enabled cycle, marks on alternating rails.
   Assumes the enable is driven at the clock edge. */
`timescale 1ns/1ps
`default_nettype none
module lam_far_side (
    // Clock, reset and control
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_enable,
    input  wire logic i_marks,
    // Bit stream
    output logic      o_valid,
    output logic      o_pos,
    output logic      o_neg
);
    logic polarity_q;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) polarity_q <= 1'b0;
        else polarity_q <= !polarity_q;
    end
    // Rails toggle between intervals so that stale data is never mistaken for a hold.
    assign o_valid = i_enable;
    assign o_pos   = i_enable ? (i_marks & !polarity_q) : polarity_q;
    assign o_neg   = i_enable ? (i_marks & polarity_q) : !polarity_q;
endmodule
`default_nettype wire

// file: tb/tb_top.sv
/* Self-checking bench for the line alarm monitor.
   Assumes a 125 MHz clock and two far-side sources for system and receive data. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lam_pkg::*;
    logic        clk, rst_n, e1, crit, sys_en, sys_mk, rx_en, rx_mk, iv, rx_abs, tip, ring;
    logic        pa, prx, pp, pn, pc, rxc;
    lam_format_t fmt;
    logic [1:0]  thr, dur, amp, msel;
    logic [3:0]  aoc;
    logic [7:0]  es, ma, mb, ca, cb;
    wire logic   sv, sp, sn, rv, rp, rn, irq, tmi, rmi, rso, rpo, rno, rco, tto, tro;
    wire logic [7:0] sta, stb, fla, flb;
    wire logic [3:0] cev;
    int          bad_count = 0;
    int          n_checks = 0;

    lam_far_side sys_src (.i_clk(clk), .i_reset_n(rst_n), .i_enable(sys_en), .i_marks(sys_mk),
        .o_valid(sv), .o_pos(sp), .o_neg(sn));
    lam_far_side rx_src (.i_clk(clk), .i_reset_n(rst_n), .i_enable(rx_en), .i_marks(rx_mk),
        .o_valid(rv), .o_pos(rp), .o_neg(rn));
    lam_alarm_monitor DUT (.i_clk(clk), .i_reset_n(rst_n), .i_e1_mode(e1), .i_criteria_select(crit),
        .i_sys_format(fmt), .i_tx_amplitude_threshold(thr), .i_tx_absence_duration(dur),
        .i_edge_select_reg(es), .i_auto_ones_config(aoc), .i_tx_indicator_select(msel),
        .i_event_masks_a(ma), .i_event_masks_b(mb), .i_event_clear_a(ca), .i_event_clear_b(cb),
        .i_tx_sys_bit_valid(sv), .i_tx_sys_pos(sp), .i_tx_sys_neg(sn), .i_tx_interval_valid(iv),
        .i_tx_pulse_amplitude(amp), .i_rx_bit_valid(rv), .i_rx_pos(rp), .i_rx_neg(rn),
        .i_rx_clock(rxc), .i_rx_line_signal_absent(rx_abs), .i_tx_tip_data(tip),
        .i_tx_ring_data(ring), .i_pattern_active(pa), .i_pattern_in_rx(prx), .i_pattern_pos(pp),
        .i_pattern_neg(pn), .i_pattern_clock(pc), .o_status_reg_a(sta), .o_status_reg_b(stb),
        .o_event_flags_a(fla), .o_event_flags_b(flb), .o_interrupt(irq), .o_counter_event(cev),
        .o_tx_multiplex_indicator(tmi), .o_rx_multiplex_indicator(rmi), .o_rx_single_rail_out(rso),
        .o_rx_positive_rail_out(rpo), .o_rx_negative_rail_out(rno), .o_rx_clock_out(rco),
        .o_tx_line_tip(tto), .o_tx_line_ring(tro));

    always #4 clk = ~clk;

    task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Samples are taken at the falling edge, away from the edge that updates outputs.
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask

    // Sends n intervals: sel 0 system data, 1 receive data, 2 transmit amplitude.
    task automatic feed(input int n, input int sel, input logic [1:0] v);
        @(posedge clk);
        sys_en <= (sel == 0);
        rx_en  <= (sel == 1);
        iv     <= (sel == 2);
        sys_mk <= v[0];
        rx_mk  <= v[0];
        amp    <= v;
        repeat (n) @(posedge clk);
        sys_en <= 1'b0;
        rx_en  <= 1'b0;
        iv     <= 1'b0;
    endtask

    task automatic give_verdict;
        if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // =========================================================
    // Test sequence
    initial begin
        {clk, rst_n, e1, crit, sys_en, sys_mk, rx_en, rx_mk, iv, rx_abs, tip, ring} = '0;
        {pa, prx, pp, pn, pc, rxc, thr, dur, amp, aoc, ma, mb, ca, cb} = '0;
        fmt = LAM_FMT_DUAL_NRZ;
        e1 = 1'b1;
        thr = 2'h1;
        es = 8'h02;
        msel = 2'h1;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        check("status_a", 8'h00, sta);
        feed(31, 0, 2'h0); tick(3); check("status_a", 8'h00, sta);
        feed(1, 0, 2'h0); tick(3); check("status_a", 8'h02, sta);
        check("flags_a", 8'h02, fla);
        check("irq", 8'h01, {7'h00, irq});
        @(posedge clk) ma <= 8'h02;
        tick(2); check("irq", 8'h00, {7'h00, irq});
        @(posedge clk) ca <= 8'h02;
        aoc <= 4'hA;
        @(posedge clk) ca <= 8'h00;
        tick(2); check("flags_a", 8'h00, fla);
        check("rx_single", 8'h01, {7'h00, rso});
        check("tx_ones", 8'h01, {7'h00, tto ^ tro});
        @(posedge clk) pa <= 1'b1;
        prx <= 1'b1;
        tick(2); check("rx_pattern", 8'h00, {7'h00, rso});
        @(posedge clk) pa <= 1'b0;
        feed(32, 0, 2'h1); tick(3); check("status_a", 8'h00, sta);
        check("flags_a", 8'h02, fla);
        @(posedge clk) fmt <= LAM_FMT_SINGLE;
        feed(40, 0, 2'h0); tick(3); check("status_a", 8'h00, sta);
        feed(15, 2, 2'h0); tick(3); check("status_a", 8'h00, sta);
        feed(1, 2, 2'h0); tick(3); check("status_a", 8'h04, sta);
        check("flags_a", 8'h06, fla);
        check("irq", 8'h01, {7'h00, irq});
        check("tx_ind", 8'h01, {7'h00, tmi});
        feed(1, 2, 2'h1); tick(3); check("status_a", 8'h04, sta);
        feed(1, 2, 2'h2); tick(3); check("status_a", 8'h00, sta);
        @(posedge clk) crit <= 1'b1;
        feed(511, 1, 2'h1); tick(4); check("status_b", 8'h00, stb);
        feed(1, 1, 2'h1); tick(4); check("status_b", 8'h40, stb);
        check("flags_b", 8'h40, flb);
        check("rx_ind", 8'h01, {7'h00, rmi});
        @(posedge clk) crit <= 1'b0;
        feed(512, 1, 2'h0); tick(4); check("status_b", 8'h40, stb);
        feed(512, 1, 2'h0); tick(4); check("status_b", 8'h00, stb);
        give_verdict();
    end

    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
